// ===== rtl/svmc_consts.svh
`ifndef SVMC_CONSTS_SVH
`define SVMC_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SVMC_OFS_PROTECT 8'h00
`define SVMC_OFS_MODE 8'h04
`define SVMC_OFS_STATUS 8'h08
`define SVMC_OFS_CAUSE 8'h0c
`define SVMC_OFS_IRQ_STAT 8'h10
`define SVMC_OFS_IRQ_MASK 8'h14

// ----------------------------------------
// Protect keys
// ----------------------------------------
`define SVMC_KEY_UNLOCK 16'ha508
`define SVMC_KEY_LOCK 16'ha500

// ----------------------------------------
// Mode control fields and reset value
// ----------------------------------------
`define SVMC_MODE_FIRST_EN 0
`define SVMC_MODE_FIRST_RST 1
`define SVMC_MODE_SECOND_EN 2
`define SVMC_MODE_SECOND_RST 3
`define SVMC_MODE_RESET 4'h0

// ----------------------------------------
// First monitor status fields
// ----------------------------------------
`define SVMC_STAT_DET 0
`define SVMC_STAT_ACTIVE 1
`define SVMC_STAT_LEVEL 2

// ----------------------------------------
// Reset cause fields and reset value
// ----------------------------------------
`define SVMC_CAUSE_POR 0
`define SVMC_CAUSE_AON 1
`define SVMC_CAUSE_FIRST 2
`define SVMC_CAUSE_SECOND 3
`define SVMC_CAUSE_OTHER 4
`define SVMC_CAUSE_RESET 5'h01

// ----------------------------------------
// Interrupt status and mask fields
// ----------------------------------------
`define SVMC_IRQ_FIRST 0
`define SVMC_IRQ_SECOND 1

// ----------------------------------------
// Timing
// ----------------------------------------
`define SVMC_CLK_MHZ 200
`define SVMC_FIRST_STAB_US 300
`define SVMC_SECOND_STAB_US 1200
`define SVMC_FIRST_STAB_CYC (`SVMC_FIRST_STAB_US * `SVMC_CLK_MHZ)
`define SVMC_SECOND_STAB_CYC (`SVMC_SECOND_STAB_US * `SVMC_CLK_MHZ)
`define SVMC_RST_STRETCH_CYC 16

`endif

// ===== rtl/svmc_pkg.sv
package svmc_pkg;

	// Monitor channel states, one-hot
	typedef enum logic [2:0]
	{
		SVMC_IDLE = 3'b001,
		SVMC_WAIT = 3'b010,
		SVMC_RUN = 3'b100
	} svmc_state_e;

	typedef logic [31:0] svmc_word_t;

endpackage

// ===== rtl/svmc_mon_if.sv
`timescale 1ns/1ps

interface svmc_mon_if;
	logic enable;
	logic reset_mode;
	logic level;
	logic active;
	logic rise_evt;
	logic fall_evt;
	logic reset_req;

	// Control side (top) and monitor side (channel)
	modport ctl (output enable, output reset_mode, output level,
		input active, input rise_evt, input fall_evt, input reset_req);
	modport mon (input enable, input reset_mode, input level,
		output active, output rise_evt, output fall_evt, output reset_req);
endinterface

// ===== rtl/svmc_channel.sv
`timescale 1ns/1ps

module svmc_channel
#(
	parameter int STAB_CYCLES = 60000
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Monitor link
	svmc_mon_if.mon mon
);
	import svmc_pkg::*;

	localparam int CW = $clog2(STAB_CYCLES + 1);

	initial
	begin
		if (STAB_CYCLES < 1)
			$error("svmc_channel: STAB_CYCLES must be at least 1");
	end

	svmc_state_e state;
	logic [CW-1:0] cnt;
	logic prev;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire stab_done = (cnt == CW'(STAB_CYCLES - 1));
	wire activating = (state == SVMC_WAIT) && mon.enable && stab_done;
	wire running = (state == SVMC_RUN) && mon.enable;
	// At activation a low supply counts as a fall; a good one is silent
	wire next_rise = running && mon.level && !prev && !mon.reset_mode;
	wire next_fall = !mon.reset_mode &&
		((running && !mon.level && prev) || (activating && !mon.level));
	wire next_reset = mon.reset_mode && !mon.level && (running || activating);

	// State, stabilization wait and last seen level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= SVMC_IDLE;
			cnt <= '0;
			prev <= 1'b0;
		end
		else
		begin
			case (state)
				SVMC_IDLE:
				begin
					cnt <= '0;
					if (mon.enable)
						state <= SVMC_WAIT;
				end
				SVMC_WAIT:
				begin
					if (!mon.enable)
						state <= SVMC_IDLE;
					else if (stab_done)
						state <= SVMC_RUN;
					else
						cnt <= cnt + 1'b1;
				end
				SVMC_RUN:
				begin
					if (!mon.enable)
						state <= SVMC_IDLE;
				end
				default:
					state <= SVMC_IDLE;
			endcase
			prev <= mon.level;
		end
	end

	// Registered event and reset outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mon.rise_evt <= 1'b0;
			mon.fall_evt <= 1'b0;
			mon.reset_req <= 1'b0;
			mon.active <= 1'b0;
		end
		else
		begin
			mon.rise_evt <= next_rise;
			mon.fall_evt <= next_fall;
			mon.reset_req <= next_reset;
			mon.active <= running || activating;
		end
	end

endmodule

// ===== rtl/svmc_top.sv
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
`include "svmc_consts.svh"

// Functional notes
// - Always-on monitor holds reset while supply low.
// - Always-on drop asserts reset until supply recovers.
// - First monitor compares after 300 us wait.
// - First monitor interrupts on rise, interrupt mode.
// - First monitor interrupts on fall, interrupt mode.
// - Second monitor interrupts on rise and fall.
// - First monitor events set flag; software clears.
// - No interrupt when activated with supply good.
// - Reset mode: low supply when active resets.
// - Re-enable with low supply repeats reset cycle.
// - No reset when activated with supply good.
// - Reset cause register records latest reset source.
// - Monitor reset clears its mode bits, stops it.
// - Mode control writable only after unlock key.
// - Second monitor active after 1200 us wait.
module svmc_top
#(
	parameter int FIRST_STAB_CYCLES = `SVMC_FIRST_STAB_CYC,
	parameter int SECOND_STAB_CYCLES = `SVMC_SECOND_STAB_CYC,
	parameter int RST_STRETCH_CYCLES = `SVMC_RST_STRETCH_CYC
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire svmc_pkg::svmc_word_t pwdata,
	output svmc_pkg::svmc_word_t prdata,
	output logic pready,
	output logic pslverr,
	// Comparators, high when supply at or above threshold
	input wire logic always_on_cmp,
	input wire logic first_prog_cmp,
	input wire logic second_prog_cmp,
	// Other internal reset seen, one-cycle pulse
	input wire logic other_reset_evt,
	// Outputs to the system
	output logic sys_reset_req,
	output logic first_irq_req,
	output logic second_irq_req,
	output logic irq
);
	import svmc_pkg::*;

	localparam int SW = $clog2(RST_STRETCH_CYCLES + 1);

	initial
	begin
		if (FIRST_STAB_CYCLES < 1 || SECOND_STAB_CYCLES < 1)
			$error("svmc_top: stabilization counts must be at least 1");
		if (RST_STRETCH_CYCLES < 1)
			$error("svmc_top: RST_STRETCH_CYCLES must be at least 1");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [2:0] cmp_meta;
	logic [2:0] cmp_sync;
	logic aon_prev;
	logic unlocked;
	logic [3:0] mode;
	logic det_flag;
	logic [4:0] cause;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic [SW-1:0] stretch;

	svmc_mon_if first_if ();
	svmc_mon_if second_if ();

	// ----------------------------------------
	// Comparator synchronizers
	// ----------------------------------------
	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmp_meta <= 3'h0;
			cmp_sync <= 3'h0;
			aon_prev <= 1'b0;
		end
		else
		begin
			cmp_meta <= {second_prog_cmp, first_prog_cmp, always_on_cmp};
			cmp_sync <= cmp_meta;
			aon_prev <= cmp_sync[0];
		end
	end

	wire aon_good = cmp_sync[0];
	// Only a real drop is a cause; the sync fill after power-on is not
	wire aon_fall = aon_prev && !aon_good;

	// ----------------------------------------
	// Monitor channels
	// ----------------------------------------
	assign first_if.enable = mode[`SVMC_MODE_FIRST_EN];
	assign first_if.reset_mode = mode[`SVMC_MODE_FIRST_RST];
	assign first_if.level = cmp_sync[1];
	assign second_if.enable = mode[`SVMC_MODE_SECOND_EN];
	assign second_if.reset_mode = mode[`SVMC_MODE_SECOND_RST];
	assign second_if.level = cmp_sync[2];

	svmc_channel #(.STAB_CYCLES(FIRST_STAB_CYCLES)) u_first
	(
		.pclk(pclk),
		.presetn(presetn),
		.mon(first_if.mon)
	);

	svmc_channel #(.STAB_CYCLES(SECOND_STAB_CYCLES)) u_second
	(
		.pclk(pclk),
		.presetn(presetn),
		.mon(second_if.mon)
	);

	wire first_evt = first_if.rise_evt || first_if.fall_evt;
	wire second_evt = second_if.rise_evt || second_if.fall_evt;
	wire mon_reset = first_if.reset_req || second_if.reset_req;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	// Answer comes one cycle after setup, so read data can be a flop
	wire setup = psel && !penable;
	wire done = psel && penable && pready;
	wire wr = done && pwrite && !pslverr;
	wire rd = done && !pwrite && !pslverr;
	wire hit_protect = (paddr == `SVMC_OFS_PROTECT);
	wire hit_mode = (paddr == `SVMC_OFS_MODE);
	wire hit_status = (paddr == `SVMC_OFS_STATUS);
	wire hit_cause = (paddr == `SVMC_OFS_CAUSE);
	wire hit_irq_stat = (paddr == `SVMC_OFS_IRQ_STAT);
	wire hit_irq_mask = (paddr == `SVMC_OFS_IRQ_MASK);
	wire unmapped = !(hit_protect || hit_mode || hit_status || hit_cause ||
		hit_irq_stat || hit_irq_mask);

	// Read mux
	wire [2:0] status_view = {cmp_sync[1], first_if.active, det_flag};
	wire svmc_word_t rdata =
		hit_protect ? {31'h0000_0000, unlocked} :
		hit_mode ? {28'h000_0000, mode} :
		hit_status ? {29'h0000_0000, status_view} :
		hit_cause ? {27'h000_0000, cause} :
		hit_irq_stat ? {30'h0000_0000, irq_stat} :
		hit_irq_mask ? {30'h0000_0000, irq_mask} :
		32'h0000_0000;

	// Bus answer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && unmapped;
			if (setup && !pwrite)
				prdata <= rdata;
		end
	end

	// ----------------------------------------
	// Write protection
	// ----------------------------------------
	wire key_wr = wr && hit_protect;
	wire next_unlocked = (key_wr && pwdata[15:0] == `SVMC_KEY_UNLOCK) ? 1'b1 :
		(key_wr && pwdata[15:0] == `SVMC_KEY_LOCK) ? 1'b0 : unlocked;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			unlocked <= 1'b0;
		else
			unlocked <= next_unlocked;
	end

	// ----------------------------------------
	// Mode control
	// ----------------------------------------
	// A monitor reset clears that monitor's bits and beats a write
	wire mode_wr = wr && hit_mode && unlocked;
	wire [3:0] mode_written = mode_wr ? pwdata[3:0] : mode;
	wire [3:0] first_clr = first_if.reset_req ? 4'h3 : 4'h0;
	wire [3:0] second_clr = second_if.reset_req ? 4'hc : 4'h0;
	wire [3:0] next_mode = mode_written & ~(first_clr | second_clr);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode <= `SVMC_MODE_RESET;
		else
			mode <= next_mode;
	end

	// ----------------------------------------
	// Detection flag
	// ----------------------------------------
	// Cleared by writing zero; a new event in that cycle wins
	wire det_clr = wr && hit_status && !pwdata[`SVMC_STAT_DET];
	wire next_det = first_evt || (det_flag && !det_clr);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			det_flag <= 1'b0;
		else
			det_flag <= next_det;
	end

	// ----------------------------------------
	// Reset cause
	// ----------------------------------------
	// Write one to clear; a new cause replaces the old record
	wire [4:0] new_cause = {other_reset_evt, second_if.reset_req,
		first_if.reset_req, aon_fall, 1'b0};
	wire [4:0] cause_clr = (wr && hit_cause) ? pwdata[4:0] : 5'h00;
	wire [4:0] next_cause = (|new_cause) ? (new_cause | (cause & new_cause)) :
		(cause & ~cause_clr);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cause <= `SVMC_CAUSE_RESET;
		else
			cause <= next_cause;
	end

	// ----------------------------------------
	// Reset request
	// ----------------------------------------
	// Stretch keeps a monitor reset visible after its mode bits clear
	wire [SW-1:0] next_stretch = mon_reset ? SW'(RST_STRETCH_CYCLES) :
		(stretch != '0) ? stretch - 1'b1 : stretch;
	wire next_sys_reset = !aon_good || mon_reset || (stretch != '0);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stretch <= '0;
			sys_reset_req <= 1'b1;
		end
		else
		begin
			stretch <= next_stretch;
			sys_reset_req <= next_sys_reset;
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	// Read of status clears it; an event in that cycle is kept
	wire stat_rd = rd && hit_irq_stat;
	wire [1:0] stat_set = {second_evt, first_evt};
	wire [1:0] next_irq_stat = stat_set | (stat_rd ? 2'h0 : irq_stat);
	wire [1:0] next_irq_mask = (wr && hit_irq_mask) ? pwdata[1:0] : irq_mask;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_stat <= 2'h0;
			irq_mask <= 2'h0;
			irq <= 1'b0;
		end
		else
		begin
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			irq <= |(next_irq_stat & next_irq_mask);
		end
	end

	// Per-monitor request pulses
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			first_irq_req <= 1'b0;
			second_irq_req <= 1'b0;
		end
		else
		begin
			first_irq_req <= first_evt;
			second_irq_req <= second_evt;
		end
	end

endmodule

// ===== bench/svmc_supply_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Supply and comparator model
// ----------------------------------------
module svmc_supply_model
(
	// Supply level: 0 below all thresholds, 3 above all
	input wire logic [1:0] vcc,
	// Comparator outputs
	output logic always_on_cmp,
	output logic first_prog_cmp,
	output logic second_prog_cmp
);
	// Thresholds ordered with always-on lowest, so no forbidden pairing arises
	assign always_on_cmp = vcc >= 2'h1;
	assign first_prog_cmp = vcc >= 2'h2;
	assign second_prog_cmp = vcc >= 2'h3;
endmodule

// ===== bench/svmc_top_sva.sv
`timescale 1ns/1ps

// ----------------------------------------
// Port checker
// ----------------------------------------
module svmc_chk
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Comparators and outputs
	input wire logic always_on_cmp,
	input wire logic first_prog_cmp,
	input wire logic second_prog_cmp,
	input wire logic sys_reset_req,
	input wire logic first_irq_req,
	input wire logic second_irq_req
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Steps: setup phase, sustained low supply
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_aon_low;
		!always_on_cmp [*4];
	endsequence

	AST_READY: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	AST_READY_ONE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_ERR_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_AON_RESET: assert property (s_aon_low |-> sys_reset_req)
		else $error("no reset while supply low");
	AST_FIRST_PULSE: assert property (first_irq_req |=> !first_irq_req)
		else $error("first request not a pulse");
	AST_SECOND_PULSE: assert property (second_irq_req |=> !second_irq_req)
		else $error("second request not a pulse");
	AST_FIRST_QUIET: assert property (first_prog_cmp [*8] |-> !first_irq_req)
		else $error("first request with steady good supply");
	AST_SECOND_QUIET: assert property (second_prog_cmp [*8] |-> !second_irq_req)
		else $error("second request with steady good supply");
endmodule

bind svmc_top svmc_chk svmc_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .always_on_cmp(always_on_cmp),
	.first_prog_cmp(first_prog_cmp), .second_prog_cmp(second_prog_cmp),
	.sys_reset_req(sys_reset_req), .first_irq_req(first_irq_req),
	.second_irq_req(second_irq_req));

// ===== bench/svmc_top_tb.sv
`timescale 1ns/1ps

module svmc_top_tb;
	import svmc_pkg::*;
	localparam int FST = 20;
	localparam int SST = 40;
	localparam svmc_word_t ALL = 32'hffff_ffff;
	logic pclk, presetn, psel, penable, pwrite, other_reset_evt, pready, pslverr;
	logic sys_reset_req, first_irq_req, second_irq_req, irq, last_err, rst_q;
	logic always_on_cmp, first_prog_cmp, second_prog_cmp;
	logic [7:0] paddr;
	logic [1:0] vcc;
	svmc_word_t pwdata, prdata, rd;
	int mismatches, samples_checked, n1, n2, nrst;

	svmc_top #(.FIRST_STAB_CYCLES(FST), .SECOND_STAB_CYCLES(SST), .RST_STRETCH_CYCLES(4))
	svmc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .always_on_cmp(always_on_cmp), .first_prog_cmp(first_prog_cmp),
		.second_prog_cmp(second_prog_cmp), .other_reset_evt(other_reset_evt),
		.sys_reset_req(sys_reset_req), .first_irq_req(first_irq_req),
		.second_irq_req(second_irq_req), .irq(irq));
	svmc_supply_model svmc_supply_model_inst (.vcc(vcc), .always_on_cmp(always_on_cmp),
		.first_prog_cmp(first_prog_cmp), .second_prog_cmp(second_prog_cmp));

	// Clock
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// Event counters, sampled mid-cycle so registered outputs have settled
	always @(negedge pclk)
	begin
		n1 += first_irq_req;
		n2 += second_irq_req;
		nrst += sys_reset_req && !rst_q;
		rst_q = sys_reset_req;
	end

	task chk(input string nm, input svmc_word_t e, input svmc_word_t g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One transfer; waits for ready without assuming its latency
	task apb(input logic w, input logic [7:0] a, input svmc_word_t d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdchk(input string nm, input logic [7:0] a, input svmc_word_t m, input svmc_word_t e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd & m);
	endtask

	task mode(input svmc_word_t m);
		apb(1'b1, 8'h00, 32'h0000_a508);
		apb(1'b1, 8'h04, m);
	endtask

	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task t_reset;
		cyc(6); // Lets the reset request drop once the supply sync fills
		@(negedge pclk);
		chk("reset req", 32'h0000_0000, {31'h0, sys_reset_req});
		rdchk("cause", 8'h0c, ALL, 32'h0000_0001);
		apb(1'b1, 8'h04, 32'h0000_0001);
		rdchk("locked mode", 8'h04, ALL, 32'h0000_0000);
		rdchk("unmapped", 8'h20, 32'h0000_0000, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, {31'h0, last_err});
		$display("test reset done");
	endtask

	task t_first_irq;
		apb(1'b1, 8'h14, 32'h0000_0003);
		mode(32'h0000_0001);
		cyc(FST - 6);
		chk("early event", 0, n1);
		cyc(20);
		@(negedge pclk);
		chk("fall event", 1, n1);
		chk("irq", 32'h0000_0001, {31'h0, irq});
		rdchk("det", 8'h08, 32'h0000_0001, 32'h0000_0001);
		rdchk("irq stat", 8'h10, ALL, 32'h0000_0001);
		cyc(2);
		@(negedge pclk);
		chk("irq cleared", 32'h0000_0000, {31'h0, irq});
		apb(1'b1, 8'h08, 32'h0000_0000);
		rdchk("det clear", 8'h08, 32'h0000_0001, 32'h0000_0000);
		vcc <= 2'h2;
		cyc(10);
		chk("rise event", 2, n1);
		vcc <= 2'h1;
		cyc(10);
		chk("fall again", 3, n1);
		$display("test first interrupt done");
	endtask

	// Second monitor with its interrupt masked
	task t_second;
		rdchk("irq stat pre", 8'h10, ALL, 32'h0000_0001);
		apb(1'b1, 8'h14, 32'h0000_0001);
		mode(32'h0000_0004);
		cyc(SST - 6);
		chk("early second", 0, n2);
		cyc(20);
		chk("second low", 1, n2);
		vcc <= 2'h3;
		cyc(10);
		chk("second rise", 2, n2);
		vcc <= 2'h1;
		cyc(10);
		@(negedge pclk);
		chk("second fall", 3, n2);
		chk("first idle", 3, n1);
		chk("masked irq", 32'h0000_0000, {31'h0, irq});
		rdchk("irq stat 2", 8'h10, ALL, 32'h0000_0002);
		$display("test second done");
	endtask

	task t_quiet;
		mode(32'h0000_0000);
		vcc <= 2'h3;
		mode(32'h0000_0001);
		cyc(FST + 15);
		chk("no event", 3, n1);
		mode(32'h0000_0000);
		mode(32'h0000_0003);
		cyc(FST + 15);
		chk("no reset", 0, nrst);
		$display("test quiet done");
	endtask

	task t_first_rst;
		vcc <= 2'h1;
		cyc(20);
		chk("first reset", 1, nrst);
		rdchk("mode cleared", 8'h04, ALL, 32'h0000_0000);
		rdchk("cause first", 8'h0c, ALL, 32'h0000_0004);
		mode(32'h0000_0003);
		cyc(FST + 15);
		chk("repeat reset", 2, nrst);
		rdchk("mode again", 8'h04, ALL, 32'h0000_0000);
		$display("test first reset done");
	endtask

	task t_aon;
		vcc <= 2'h0;
		cyc(6);
		@(negedge pclk);
		chk("aon low", 32'h0000_0001, {31'h0, sys_reset_req});
		rdchk("cause aon", 8'h0c, ALL, 32'h0000_0002);
		vcc <= 2'h1;
		cyc(6);
		@(negedge pclk);
		chk("aon back", 32'h0000_0000, {31'h0, sys_reset_req});
		@(posedge pclk);
		other_reset_evt <= 1'b1;
		@(posedge pclk);
		other_reset_evt <= 1'b0;
		rdchk("cause other", 8'h0c, ALL, 32'h0000_0010);
		$display("test always-on done");
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, other_reset_evt, paddr, pwdata} = '0;
		vcc = 2'h1;
		rst_q = 1'b1;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_first_irq();
		t_second();
		t_quiet();
		t_first_rst();
		t_aon();
		summarize();
	end

	// Watchdog, well beyond the expected run length
	initial
	begin
		cyc(6000);
		mismatches++;
		summarize();
	end
endmodule
